// >>> sac_pkg.sv
/*
 * Constants, register map and types for the converter control block.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
// What this block does
// - Eight-bit result from one of four channels
// - On finish store result, flag or interrupt in same cycle
// - Selected pin is forced to converter input
// - Unselected shared pins stay ordinary port pins
// - Port writes never drive the selected pin
// - Selected pin reads zero, or latch if output
// - Supply gives ff, ground 00, rails saturate
// - Conversion lasts sixteen converter clock ticks
// - Start on first tick after control write
// - Continuous mode overwrites result every conversion
// - Continuous runs until its bit is cleared
// - Done flag set per conversion until result read
// - Interrupt enable requests interrupt per conversion
// - Done flag stays zero while interrupts enabled
// - Runs in wait mode, interrupt can wake
// - Stop mode idles converter, aborts conversion
// - After stop, resume without reconfiguration
// - Select codes: pins 0-3, supply, ground, off
// - Result read or control write clears interrupt
// - Single mode: one conversion per start
// - Prescaler divides by 1,2,4,8 or 16
package sac_pkg;
    // Register byte addresses
    localparam logic [7:0] SAC_SCR_ADR = 8'h3c;
    localparam logic [7:0] SAC_RES_ADR = 8'h40;
    localparam logic [7:0] SAC_DIV_ADR = 8'h44;
    localparam logic [7:0] SAC_DAT_ADR = 8'h48;
    localparam logic [7:0] SAC_DIR_ADR = 8'h4c;
    // Control register fields
    localparam int SAC_DONE_BIT = 7;
    localparam int SAC_IE_BIT = 6;
    localparam int SAC_CONT_BIT = 5;
    localparam int SAC_SEL_W = 5;
    localparam int SAC_RES_W = 8;
    localparam int SAC_DIV_W = 3;
    localparam int SAC_PINS = 4;
    // Select codes and reset values
    localparam logic [4:0] SAC_SEL_OFF = 5'h1f;
    localparam logic [4:0] SAC_SEL_VDD = 5'h1d;
    localparam logic [4:0] SAC_SEL_VSS = 5'h1e;
    localparam logic [7:0] SAC_RES_RST = 8'h00;
    localparam logic [2:0] SAC_DIV_RST = 3'h0;
    localparam logic [3:0] SAC_PORT_RST = 4'h0;
    // Sequencing: ticks numbered 0..15, bits decided on 1..8
    localparam logic [3:0] SAC_CONV_LAST = 4'hf;
    localparam logic [3:0] SAC_BITS_LAST = 4'h8;
    localparam logic [3:0] SAC_CNT_FIRST = 4'h1;
    localparam logic [7:0] SAC_SAR_MSB = 8'h80;
    // Prescaler terminal counts for ratios 1,2,4,8,16
    localparam logic [3:0] SAC_LIM_D1 = 4'h0;
    localparam logic [3:0] SAC_LIM_D2 = 4'h1;
    localparam logic [3:0] SAC_LIM_D4 = 4'h3;
    localparam logic [3:0] SAC_LIM_D8 = 4'h7;
    localparam logic [3:0] SAC_LIM_D16 = 4'hf;
    typedef enum {SAC_IDLE, SAC_CONV} sac_state_t;
endpackage

// >>> sac_tick_if.sv
/*
 * Carrier between the control top and its prescaler.
 * Assumes both ends share clk_i.
 */
interface sac_tick_if;
    import sac_pkg::*;
    logic [SAC_DIV_W-1:0] div;
    logic hold;
    logic tick;
    modport gen(input div, input hold, output tick);
    modport sink(output div, output hold, input tick);
endinterface

// >>> sac_clk_div.sv
/*
 * Prescaler making the one-cycle converter clock tick.
 * Assumes synchronous active-high reset on clk_i.
 */
module sac_clk_div
    import sac_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Divider carrier
    sac_tick_if.gen tif
);
    logic [3:0] cnt_reg, cnt_next, lim;
    logic tick_reg, tick_next;

    // Terminal count from the divider code
    always_comb begin
        lim = SAC_LIM_D16;
        if (!tif.div[2]) begin
            case (tif.div[1:0])
                2'h0: lim = SAC_LIM_D1;
                2'h1: lim = SAC_LIM_D2;
                2'h2: lim = SAC_LIM_D4;
                default: lim = SAC_LIM_D8;
            endcase
        end
        // A count left above a smaller new limit ticks at once instead of wrapping
        cnt_next = (tif.hold || cnt_reg >= lim) ? 4'h0 : cnt_reg + 4'h1;
        tick_next = !tif.hold && cnt_reg >= lim;
    end

    // Counter and tick registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 4'h0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tif.tick = tick_reg;

    a_div_one_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        (tif.div == SAC_DIV_RST && !tif.hold) [*2] |=> tif.tick)
        else $error("Divide-by-one tick missing");
endmodule

// >>> sac_adc_control.sv
/*
 * Converter control top: Wishbone registers, shared pin override,
 * successive-approximation sequencer, flag and interrupt.
 * Assumes the comparator and pin inputs are synchronous to clk_i.
 */
module sac_adc_control
    import sac_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Low power and interrupt
    input wire logic stop_i,
    output logic irq_o,
    // Analog side
    input wire logic cmp_i,
    output logic [SAC_RES_W-1:0] dac_o,
    output logic [SAC_SEL_W-1:0] input_select_o,
    // Shared port pins
    input wire logic [SAC_PINS-1:0] pin_i,
    output logic [SAC_PINS-1:0] pin_o,
    output logic [SAC_PINS-1:0] pin_oe_o,
    output logic [SAC_PINS-1:0] pin_analog_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sac_tick_if tif();
    logic tk;

    // Register state
    logic ie_reg, ie_next, cont_reg, cont_next, done_reg, done_next;
    logic irq_reg, irq_next;
    logic [SAC_SEL_W-1:0] sel_reg, sel_next;
    logic [SAC_DIV_W-1:0] div_reg, div_next;
    logic [SAC_RES_W-1:0] res_reg, res_next;
    logic [SAC_PINS-1:0] lat_reg, lat_next, ddr_reg, ddr_next;
    // Bus state
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic req, wr, rd, wr_scr, rd_res;
    logic [7:0] rdata;
    // Sequencer state
    sac_state_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [SAC_RES_W-1:0] sar_reg, sar_next;
    logic pend_reg, pend_next, fin, load, off;
    logic [2:0] bi;
    // Pin state
    logic [SAC_PINS-1:0] seld, prd;
    logic [SAC_PINS-1:0] po_reg, poe_reg, pan_reg;

    // Prescaler, held while powered off or stopped
    assign tif.div = div_reg;
    assign tif.hold = stop_i || off;
    assign tk = tif.tick;

    sac_clk_div u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tif(tif)
    );

    // Bus decode; side effects act at the edge that raises ack
    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;
    assign wr_scr = wr && wb_adr_i == SAC_SCR_ADR;
    assign rd_res = rd && wb_adr_i == SAC_RES_ADR;
    // Power-off decode straight from the write data: holds at the writing edge, no loop
    assign off = (wr_scr ? wb_dat_i[SAC_SEL_W-1:0] : sel_reg) == SAC_SEL_OFF;

    // Per-pin override and read path
    genvar gi;
    generate
        for (gi = 0; gi < SAC_PINS; gi++) begin : g_pin
            assign seld[gi] = sel_reg == SAC_SEL_W'(gi);
            assign prd[gi] = seld[gi] ? (ddr_reg[gi] && lat_reg[gi])
                : (ddr_reg[gi] ? lat_reg[gi] : pin_i[gi]);
        end
    endgenerate

    // Read mux; unmapped addresses read zero
    always_comb begin
        case (wb_adr_i)
            SAC_SCR_ADR: rdata = {done_reg, ie_reg, cont_reg, sel_reg};
            SAC_RES_ADR: rdata = res_reg;
            SAC_DIV_ADR: rdata = {5'h00, div_reg};
            SAC_DAT_ADR: rdata = {4'h0, prd};
            SAC_DIR_ADR: rdata = {4'h0, ddr_reg};
            default: rdata = 8'h00;
        endcase
        ack_next = req;
        dat_next = rd ? {24'h000000, rdata} : 32'h00000000;
    end

    // Bus response registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    // Software registers, flag and interrupt request
    always_comb begin
        ie_next = ie_reg;
        cont_next = cont_reg;
        sel_next = sel_reg;
        div_next = div_reg;
        lat_next = lat_reg;
        ddr_next = ddr_reg;
        res_next = res_reg;
        if (wr) begin
            case (wb_adr_i)
                SAC_SCR_ADR: begin
                    ie_next = wb_dat_i[SAC_IE_BIT];
                    cont_next = wb_dat_i[SAC_CONT_BIT];
                    sel_next = wb_dat_i[SAC_SEL_W-1:0];
                end
                SAC_DIV_ADR: div_next = wb_dat_i[SAC_DIV_W-1:0];
                SAC_DAT_ADR: lat_next = wb_dat_i[SAC_PINS-1:0];
                SAC_DIR_ADR: ddr_next = wb_dat_i[SAC_PINS-1:0];
                default: ;
            endcase
        end
        if (fin) begin
            res_next = sar_reg;
        end
        // Read clears, a finishing conversion sets and wins
        done_next = done_reg;
        if (rd_res) begin
            done_next = 1'b0;
        end
        if (fin && !ie_reg) begin
            done_next = 1'b1;
        end
        if (ie_next) begin
            done_next = 1'b0;
        end
        // No low-power gating: the request can wake from wait
        irq_next = irq_reg;
        if (rd_res || wr_scr) begin
            irq_next = 1'b0;
        end
        if (fin && ie_reg) begin
            irq_next = 1'b1;
        end
    end

    // Software register storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ie_reg <= 1'b0;
            cont_reg <= 1'b0;
            done_reg <= 1'b0;
            irq_reg <= 1'b0;
            sel_reg <= SAC_SEL_OFF;
            div_reg <= SAC_DIV_RST;
            res_reg <= SAC_RES_RST;
            lat_reg <= SAC_PORT_RST;
            ddr_reg <= SAC_PORT_RST;
        end else begin
            ie_reg <= ie_next;
            cont_reg <= cont_next;
            done_reg <= done_next;
            irq_reg <= irq_next;
            sel_reg <= sel_next;
            div_reg <= div_next;
            res_reg <= res_next;
            lat_reg <= lat_next;
            ddr_reg <= ddr_next;
        end
    end

    // Conversion sequencer
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        sar_next = sar_reg;
        pend_next = pend_reg || wr_scr;
        fin = 1'b0;
        load = 1'b0;
        bi = 3'(SAC_BITS_LAST - cnt_reg);
        if (stop_i || off) begin
            st_next = SAC_IDLE;
            if (off) begin
                pend_next = 1'b0;
            end else if (st_reg == SAC_CONV) begin
                pend_next = 1'b1;
            end
        end else if (wr_scr) begin
            st_next = SAC_IDLE;
        end else if (tk) begin
            if (st_reg == SAC_IDLE) begin
                load = pend_reg;
            end else if (cnt_reg == 4'h0) begin
                load = 1'b1;
            end else begin
                if (cnt_reg <= SAC_BITS_LAST) begin
                    if (!cmp_i) begin
                        sar_next[bi] = 1'b0;
                    end
                    if (bi != 3'h0) begin
                        sar_next[bi-3'h1] = 1'b1;
                    end
                end
                if (cnt_reg == SAC_CONV_LAST) begin
                    fin = 1'b1;
                    if (cont_reg) begin
                        cnt_next = 4'h0;
                    end else begin
                        st_next = SAC_IDLE;
                    end
                end else begin
                    cnt_next = cnt_reg + 4'h1;
                end
            end
            if (load) begin
                st_next = SAC_CONV;
                cnt_next = SAC_CNT_FIRST;
                sar_next = SAC_SAR_MSB;
                pend_next = 1'b0;
            end
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= SAC_IDLE;
            cnt_reg <= 4'h0;
            sar_reg <= SAC_RES_RST;
            pend_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            sar_reg <= sar_next;
            pend_reg <= pend_next;
        end
    end

    // Pin drive: selected pin released and routed to the converter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            po_reg <= SAC_PORT_RST;
            poe_reg <= SAC_PORT_RST;
            pan_reg <= SAC_PORT_RST;
        end else begin
            po_reg <= lat_reg;
            poe_reg <= ddr_reg & ~seld;
            pan_reg <= seld;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_o = irq_reg;
    assign dac_o = sar_reg;
    assign input_select_o = sel_reg;
    assign pin_o = po_reg;
    assign pin_oe_o = poe_reg;
    assign pin_analog_o = pan_reg;

    // Helper: ticks seen since the conversion was loaded
    logic [4:0] h_ticks;
    always_ff @(posedge clk_i) begin
        if (rst_i || load) begin
            h_ticks <= 5'h00;
        end else if (tk && st_reg == SAC_CONV) begin
            h_ticks <= h_ticks + 5'h01;
        end
    end

    // Load tick and finishing tick frame the counted ticks: sixteen in all
    a_conv_tick_count: assert property (fin
        |-> h_ticks == {1'b0, SAC_CONV_LAST - SAC_CNT_FIRST})
        else $error("Conversion did not span sixteen ticks");
    a_start_on_tick: assert property ((st_reg == SAC_IDLE ##1 st_reg == SAC_CONV)
        |-> $past(tk) && $past(pend_reg))
        else $error("Conversion started off a tick or unrequested");
    a_pin_not_driven: assert property ((pin_oe_o & pin_analog_o) == 4'h0)
        else $error("Selected pin is being driven");
    a_pin_one_sel: assert property ($onehot0(pin_analog_o))
        else $error("More than one pin routed to converter");
    a_flag_ie_zero: assert property (ie_reg |-> !done_reg)
        else $error("Done flag set while interrupts enabled");
    a_flag_on_done: assert property (fin && !ie_reg && !wr_scr |=> done_reg)
        else $error("Done flag not set after conversion");
    a_irq_on_done: assert property (fin && ie_reg |=> irq_o ##1 (irq_o || $past(rd_res)
        || $past(wr_scr)))
        else $error("Interrupt not raised or dropped early");
    a_irq_clear_rd: assert property ((rd_res || wr_scr) && !fin |=> !irq_o)
        else $error("Interrupt not cleared by read or write");
    a_result_store: assert property (fin |=> res_reg == $past(sar_reg))
        else $error("Result register not updated");
    a_stop_aborts: assert property (stop_i |=> st_reg == SAC_IDLE && !$rose(irq_o))
        else $error("Converter active during stop");
    a_single_ends: assert property (fin && !cont_reg && !stop_i |=> st_reg == SAC_IDLE)
        else $error("Single conversion did not stop");
    a_off_idle: assert property (sel_reg == SAC_SEL_OFF |-> st_reg == SAC_IDLE)
        else $error("Converter running while powered off");
endmodule

// >>> sac_analog_src.sv
/*
 * Far-side model: analog sources on the shared pins and the comparator.
 * Assumes the trial code and pin routing come from the control block.
 */
module sac_analog_src
    import sac_pkg::*;
(
    // Routing and trial code
    input wire logic [SAC_SEL_W-1:0] sel_i,
    input wire logic [SAC_PINS-1:0] route_i,
    input wire logic [SAC_RES_W-1:0] dac_i,
    // Pin voltages, one byte per pin
    input wire logic [31:0] level_i,
    // Comparator result
    output logic cmp_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] vin;
    // Mux: internal supply or ground, else routed pin, else a wandering node
    always_comb begin
        vin = {4{dac_i[1:0]}} ^ 8'h5a;
        for (int i = 0; i < SAC_PINS; i++) begin
            if (route_i[i]) vin = level_i[8*i +: 8];
        end
        if (sel_i == SAC_SEL_VDD) vin = 8'hff;
        if (sel_i == SAC_SEL_VSS) vin = 8'h00;
    end
    // At or above the trial code answers one
    assign cmp_o = (vin >= dac_i);
endmodule

// >>> sar_adc_control_tb_top.sv
/*
 * Testbench for the converter control block over Wishbone.
 * Assumes the analog source model and the design files are compiled first.
 */
module sar_adc_control_tb_top
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic stop_i = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] ext = 4'hf;
    logic [31:0] level = 32'hff17c35a;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_o, cmp;
    logic [7:0] dac;
    logic [4:0] input_select_o;
    logic [3:0] pin_o, pin_oe_o, pin_analog_o;
    wire logic [3:0] pin_w = (pin_oe_o & pin_o) | (~pin_oe_o & ext);
    int mismatches = 0;
    int n_checks = 0;
    // Bus clock, 100 ns
    always #50 clk_i = ~clk_i;
    sac_adc_control u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .stop_i(stop_i), .irq_o(irq_o), .cmp_i(cmp), .dac_o(dac),
        .input_select_o(input_select_o), .pin_i(pin_w), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .pin_analog_o(pin_analog_o)
    );
    sac_analog_src u_src (
        .sel_i(input_select_o), .route_i(pin_analog_o), .dac_i(dac), .level_i(level),
        .cmp_o(cmp)
    );
    // Verdict and end of run
    task automatic end_sim;
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Compare a byte
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Compare a flag
    task automatic chk_flag(input logic got, input logic exp);
        chk_byte({7'h0, got}, {7'h0, exp});
    endtask
    // One classic Wishbone cycle, released after ack is seen or after 50 clocks without it
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [7:0] d,
                            output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) mismatches++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb_cycle(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        wb_cycle(1'b0, a, 8'h00, q);
    endtask
    // Bounded waits for interrupt and done flag
    task automatic wait_irq(output int n);
        n = 0;
        while (irq_o !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task automatic wait_done(output logic [7:0] q);
        int n;
        n = 0;
        do begin
            rd(SAC_SCR_ADR, q);
            n++;
        end while (q[7] !== 1'b1 && n < 60);
        chk_flag(q[7], 1'b1);
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        end_sim();
    end
    // Main sequence
    initial begin
        logic [7:0] q;
        logic [2:0] d;
        int n, r;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(SAC_SCR_ADR, q);
        chk_byte(q, 8'h1f);
        chk_byte({3'h0, input_select_o}, {3'h0, SAC_SEL_OFF});
        rd(8'h50, q);
        chk_byte(q, 8'h00);
        // Every prescaler ratio, interrupt mode
        for (int c = 0; c < 6; c++) begin
            d = (c == 5) ? 3'h7 : 3'(c);
            r = (c > 3) ? 16 : (1 << c);
            wr(SAC_DIV_ADR, {5'h0, d});
            wr(SAC_SCR_ADR, 8'h40);
            wait_irq(n);
            chk_flag(n >= 15*r+1 && n <= 16*r+2, 1'b1);
            chk_flag(irq_o, 1'b1);
            rd(SAC_SCR_ADR, q);
            chk_flag(q[7], 1'b0);
            rd(SAC_RES_ADR, q);
            chk_byte(q, level[7:0]);
            chk_flag(irq_o, 1'b0);
        end
        wr(SAC_DIV_ADR, 8'h00);
        // Single conversion with the done flag
        wr(SAC_SCR_ADR, 8'h01);
        wait_done(q);
        rd(SAC_RES_ADR, q);
        chk_byte(q, level[15:8]);
        rd(SAC_SCR_ADR, q);
        chk_byte(q, 8'h01);
        repeat (40) @(posedge clk_i);
        rd(SAC_SCR_ADR, q);
        chk_byte(q, 8'h01);
        // Continuous mode overwrites unread results
        wr(SAC_SCR_ADR, 8'h22);
        wait_done(q);
        level[23:16] <= 8'hc8;
        repeat (40) @(posedge clk_i);
        rd(SAC_RES_ADR, q);
        chk_byte(q, 8'hc8);
        wr(SAC_SCR_ADR, 8'h02);
        repeat (40) @(posedge clk_i);
        rd(SAC_RES_ADR, q);
        repeat (40) @(posedge clk_i);
        rd(SAC_SCR_ADR, q);
        chk_byte(q, 8'h02);
        // Supply and ground reference codes
        for (int k = 0; k < 2; k++) begin
            wr(SAC_SCR_ADR, k ? SAC_SEL_VSS : SAC_SEL_VDD);
            wait_done(q);
            rd(SAC_RES_ADR, q);
            chk_byte(q, k ? 8'h00 : 8'hff);
        end
        // Shared pins with pin one selected
        wr(SAC_SCR_ADR, 8'h01);
        wr(SAC_DIR_ADR, 8'h0f);
        wr(SAC_DAT_ADR, 8'h0a);
        @(posedge clk_i);
        chk_byte({4'h0, pin_oe_o}, 8'h0d);
        chk_byte({4'h0, pin_analog_o}, 8'h02);
        chk_byte({4'h0, pin_o & pin_oe_o}, 8'h08);
        rd(SAC_DAT_ADR, q);
        chk_byte(q, 8'h0a);
        wr(SAC_DIR_ADR, 8'h00);
        rd(SAC_DAT_ADR, q);
        chk_byte(q, 8'h0d);
        // Stop aborts, then the conversion resumes
        wr(SAC_SCR_ADR, 8'h40);
        repeat (5) @(posedge clk_i);
        stop_i <= 1'b1;
        repeat (40) @(posedge clk_i);
        chk_flag(irq_o, 1'b0);
        stop_i <= 1'b0;
        wait_irq(n);
        chk_flag(irq_o, 1'b1);
        rd(SAC_RES_ADR, q);
        chk_byte(q, level[7:0]);
        chk_byte(dac, level[7:0]);
        // Power down before idling
        wr(SAC_SCR_ADR, 8'h1f);
        @(posedge clk_i);
        chk_byte({4'h0, pin_analog_o}, 8'h00);
        end_sim();
    end
endmodule
